// >>> inc/asc_adc_seq_regs.vh
/*
  register map, field positions and reset values of the converter sequencing control.
  assumes a 32-bit classic wishbone slave with byte addresses; each register is one aligned word.
*/
`ifndef ASC_ADC_SEQ_REGS_VH
`define ASC_ADC_SEQ_REGS_VH

// register indexes; byte address is four times the index
`define ASC_IDX_INT_TRIG_CTL  6'h02
`define ASC_IDX_SEQ_CTL       6'h03
`define ASC_IDX_START         6'h05
`define ASC_IDX_STATUS0       6'h06
`define ASC_IDX_CONV_FLAGS    6'h07
`define ASC_IDX_CMP_EN        6'h08
`define ASC_IDX_IRQ_STATUS    6'h09
`define ASC_IDX_IRQ_MASK      6'h0a
`define ASC_IDX_RESULT_BASE   6'h10

// interrupt_trigger_control fields
`define ASC_F_TRIG_LEVEL_SEL  4
`define ASC_F_TRIG_POLARITY   3
`define ASC_F_TRIG_ENABLE     2
`define ASC_F_SEQ_DONE_IRQ_EN 1
`define ASC_F_COMPARE_IRQ_EN  0

// sequence_control fields
`define ASC_F_RESULT_JUSTIFY  7
`define ASC_F_SEQ_LEN_HI      6
`define ASC_F_SEQ_LEN_LO      3
`define ASC_F_FIFO_MODE       2
`define ASC_F_FREEZE_HI       1
`define ASC_F_FREEZE_LO       0

// start_reg, status_reg0 and irq status fields
`define ASC_F_START_SCAN      0
`define ASC_F_STAT_SEQ_DONE   7
`define ASC_F_STAT_BUSY       4
`define ASC_F_IRQ_COMPARE     0
`define ASC_F_IRQ_SEQ_DONE    1

// reset values
`define ASC_RST_INT_TRIG_CTL  8'h00
`define ASC_RST_SEQ_CTL       8'h20
`define ASC_RST_CMP_EN        16'h0000
`define ASC_RST_IRQ_MASK      2'h3

// freeze control encodings
`define ASC_FRZ_CONTINUE      2'h0
`define ASC_FRZ_RESERVED      2'h1
`define ASC_FRZ_FINISH        2'h2
`define ASC_FRZ_IMMEDIATE     2'h3

// sequence length limits and result file size
`define ASC_SEQ_LEN_MAX       4'ha
`define ASC_RESULT_LAST       4'hf

`endif

// >>> hdl/asc_adc_seq_ctl.v
/*
  sequencing control of an analog-to-digital converter: control registers over classic wishbone,
  sequence state machine, result placement (normal and fifo), per-conversion flags, interrupt,
  external trigger detection and debug freeze handling.
  assumes the analog core converts on o_conv_start, returns i_conv_done for one cycle with the raw
  12-bit result and a compare outcome, and pauses while o_conv_hold is high. i_freeze and
  i_stop_mode come from logic on the same clock; i_ext_trig is an asynchronous pin.
*/
// The Wishbone slave port was chosen for this implementation.
`include "asc_adc_seq_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module asc_adc_seq_ctl (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_reset,
  // wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // analog core
  output reg         o_conv_start,
  output reg         o_conv_abort,
  output wire        o_conv_hold,
  input  wire        i_conv_done,
  input  wire [11:0] i_conv_result,
  input  wire        i_compare_hit,
  // system pins
  input  wire        i_ext_trig,
  input  wire        i_freeze,
  input  wire        i_stop_mode,
  // interrupt
  output wire        o_irq
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_CONV   = 2'h1;
  localparam [1:0] ST_LAUNCH = 2'h2;

  // number of conversions per sequence from the length code
  function [3:0] seq_len_of;
    input [3:0] code;
    begin
      if (code == 4'h0 || code > 4'h9) begin
        seq_len_of = `ASC_SEQ_LEN_MAX;
      end else begin
        seq_len_of = code;
      end
    end
  endfunction

  // placement of the unsigned raw result in a 16-bit result register
  function [15:0] justify;
    input        right;
    input [11:0] raw;
    begin
      if (right) begin
        justify = {4'h0, raw};
      end else begin
        justify = {raw, 4'h0};
      end
    end
  endfunction

  // registers
  reg  [7:0]  int_trig_ctl_q;
  reg  [7:0]  seq_ctl_q;
  reg  [15:0] cmp_en_q;
  reg  [1:0]  irq_mask_q;
  reg         scan_q;
  reg  [15:0] conv_flag_q;
  reg         seq_done_flag_q;
  reg         cmp_evt_q;
  reg  [15:0] result_q [0:15];

  // sequencing state
  reg  [1:0]  state_q;
  reg  [3:0]  conv_cnt_q;
  reg  [3:0]  seq_pos_q;

  // trigger synchroniser and edge history
  reg         trig_meta_q;
  reg         trig_sync_q;
  reg         trig_prev_q;

  // bus decode
  wire        bus_req   = i_wb_cyc & i_wb_stb;
  wire        wr_now    = bus_req & i_wb_we & o_wb_ack;
  wire [5:0]  idx       = i_wb_adr[7:2];
  wire        wr_ctl2   = wr_now && idx == `ASC_IDX_INT_TRIG_CTL && i_wb_sel[0];
  wire        wr_ctl3   = wr_now && idx == `ASC_IDX_SEQ_CTL && i_wb_sel[0];
  wire        wr_start  = wr_now && idx == `ASC_IDX_START && i_wb_sel[0];
  wire        wr_stat0  = wr_now && idx == `ASC_IDX_STATUS0 && i_wb_sel[0];
  wire        wr_flags  = wr_now && idx == `ASC_IDX_CONV_FLAGS;
  wire        wr_cmpen  = wr_now && idx == `ASC_IDX_CMP_EN;
  wire        wr_irqst  = wr_now && idx == `ASC_IDX_IRQ_STATUS && i_wb_sel[0];
  wire        wr_irqmk  = wr_now && idx == `ASC_IDX_IRQ_MASK && i_wb_sel[0];

  // control fields
  wire        trig_level_sel  = int_trig_ctl_q[`ASC_F_TRIG_LEVEL_SEL];
  wire        trig_polarity   = int_trig_ctl_q[`ASC_F_TRIG_POLARITY];
  wire        trig_enable     = int_trig_ctl_q[`ASC_F_TRIG_ENABLE];
  wire        seq_done_irq_en = int_trig_ctl_q[`ASC_F_SEQ_DONE_IRQ_EN];
  wire        compare_irq_en  = int_trig_ctl_q[`ASC_F_COMPARE_IRQ_EN];
  wire        result_justify  = seq_ctl_q[`ASC_F_RESULT_JUSTIFY];
  wire [3:0]  seq_len_code    = seq_ctl_q[`ASC_F_SEQ_LEN_HI:`ASC_F_SEQ_LEN_LO];
  wire        fifo_mode       = seq_ctl_q[`ASC_F_FIFO_MODE];
  wire [1:0]  freeze_ctl      = seq_ctl_q[`ASC_F_FREEZE_HI:`ASC_F_FREEZE_LO];
  wire [3:0]  seq_len         = seq_len_of(seq_len_code);

  // fifo mode masks every compare enable and the compare interrupt enable
  wire        cmp_active      = ~fifo_mode & cmp_en_q[conv_cnt_q];
  wire        cmp_irq_gate    = compare_irq_en & ~fifo_mode;

  // external trigger detection
  // the edge history resets low, so a pin idling high shows a rise after reset; the trigger
  // enable also resets low, which keeps that false edge from starting a sequence
  wire        trig_rise  = trig_sync_q & ~trig_prev_q;
  wire        trig_fall  = ~trig_sync_q & trig_prev_q;
  reg         trig_hit;
  always @* begin
    case ({trig_level_sel, trig_polarity})
      2'h0:    trig_hit = trig_fall;
      2'h1:    trig_hit = trig_rise;
      2'h2:    trig_hit = ~trig_sync_q;
      2'h3:    trig_hit = trig_sync_q;
      default: trig_hit = 1'b0;
    endcase
  end
  // a level trigger restarts only once the running sequence ends
  wire        trig_start = trig_hit & trig_enable & ~i_stop_mode & (state_q == ST_IDLE);

  // freeze handling; the reserved code behaves as continue
  wire        frz_finish = i_freeze && freeze_ctl == `ASC_FRZ_FINISH;
  wire        frz_now    = i_freeze && freeze_ctl == `ASC_FRZ_IMMEDIATE;
  assign o_conv_hold = frz_now & (state_q == ST_CONV);

  // conversion completion as seen by the sequencer; ignored while idle so a late answer after
  // an abort cannot place a stale result
  wire        conv_done = i_conv_done & (state_q == ST_CONV);
  // the length is read on every step; rewriting it mid-sequence is harmless because that
  // write aborts the sequence first
  wire        last_conv = (seq_pos_q + 4'h1) == seq_len;
  wire        flag_set  = ~cmp_active | i_compare_hit;

  // trigger synchroniser: the first stage feeds only the second
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_meta_q <= i_ext_trig;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  // software control registers
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      int_trig_ctl_q <= `ASC_RST_INT_TRIG_CTL;
      seq_ctl_q      <= `ASC_RST_SEQ_CTL;
      cmp_en_q       <= `ASC_RST_CMP_EN;
      irq_mask_q     <= `ASC_RST_IRQ_MASK;
      scan_q         <= 1'b0;
    end else begin
      if (wr_ctl2) begin
        int_trig_ctl_q <= {3'h0, i_wb_dat[4:0]};
      end
      if (wr_ctl3) begin
        seq_ctl_q <= i_wb_dat[7:0];
      end
      if (wr_cmpen && i_wb_sel[0]) begin
        cmp_en_q[7:0] <= i_wb_dat[7:0];
      end
      if (wr_cmpen && i_wb_sel[1]) begin
        cmp_en_q[15:8] <= i_wb_dat[15:8];
      end
      if (wr_irqmk) begin
        irq_mask_q <= i_wb_dat[1:0];
      end
      if (wr_start) begin
        scan_q <= i_wb_dat[`ASC_F_START_SCAN];
      end
    end
  end

  // sequence state machine and conversion counter
  // a sequence_control write outranks a start write, and both outrank the running sequence,
  // so an abort never leaves a launch or a counter step pending behind it
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_q      <= ST_IDLE;
      conv_cnt_q   <= 4'h0;
      seq_pos_q    <= 4'h0;
      o_conv_start <= 1'b0;
      o_conv_abort <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      o_conv_abort <= 1'b0;
      if (wr_ctl3) begin
        state_q      <= ST_IDLE;
        conv_cnt_q   <= 4'h0;
        seq_pos_q    <= 4'h0;
        o_conv_abort <= (state_q != ST_IDLE);
      end else if (wr_start) begin
        state_q      <= ST_LAUNCH;
        conv_cnt_q   <= 4'h0;
        seq_pos_q    <= 4'h0;
        o_conv_abort <= (state_q != ST_IDLE);
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (trig_start) begin
              state_q   <= ST_LAUNCH;
              seq_pos_q <= 4'h0;
              if (!fifo_mode) begin
                conv_cnt_q <= 4'h0;
              end
            end
          end
          ST_LAUNCH: begin
            // finish-then-freeze holds off the next conversion for the breakpoint
            if (!frz_finish && !frz_now) begin
              o_conv_start <= 1'b1;
              state_q      <= ST_CONV;
            end
          end
          ST_CONV: begin
            if (conv_done) begin
              if (fifo_mode) begin
                conv_cnt_q <= (conv_cnt_q == `ASC_RESULT_LAST) ? 4'h0 : conv_cnt_q + 4'h1;
              end else if (last_conv) begin
                conv_cnt_q <= 4'h0;
              end else begin
                conv_cnt_q <= seq_pos_q + 4'h1;
              end
              if (last_conv) begin
                seq_pos_q <= 4'h0;
                state_q   <= scan_q ? ST_LAUNCH : ST_IDLE;
              end else begin
                seq_pos_q <= seq_pos_q + 4'h1;
                state_q   <= ST_LAUNCH;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // result file: no reset, validity is tracked by the conversion flags
  // a result that lands on the edge of an abort is still kept: it was complete before the write
  always @(posedge i_clk_sys) begin
    if (conv_done) begin
      result_q[conv_cnt_q] <= justify(result_justify, i_conv_result);
    end
  end

  // per-conversion flags; a hardware set wins over a same-cycle software clear. the next value is
  // built per bit and stored by one process, so the flag word keeps a single driver
  wire [15:0] conv_flag_d;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_flag
      wire set_bit = conv_done && conv_cnt_q == g && flag_set;
      wire clr_bit = wr_flags && i_wb_sel[g / 8] && i_wb_dat[g];
      assign conv_flag_d[g] = set_bit | (conv_flag_q[g] & ~clr_bit);
    end
  endgenerate

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      conv_flag_q <= 16'h0000;
    end else begin
      conv_flag_q <= conv_flag_d;
    end
  end

  // sticky event flags, write one to clear; seq done through either status view, compare only through irq status
  wire clr_seq_done = (wr_stat0 && i_wb_dat[`ASC_F_STAT_SEQ_DONE]) ||
                      (wr_irqst && i_wb_dat[`ASC_F_IRQ_SEQ_DONE]);
  wire clr_cmp_evt  = wr_irqst && i_wb_dat[`ASC_F_IRQ_COMPARE];
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      seq_done_flag_q <= 1'b0;
      cmp_evt_q       <= 1'b0;
    end else begin
      if (conv_done && last_conv) begin
        seq_done_flag_q <= 1'b1;
      end else if (clr_seq_done) begin
        seq_done_flag_q <= 1'b0;
      end
      if (conv_done && cmp_active && i_compare_hit) begin
        cmp_evt_q <= 1'b1;
      end else if (clr_cmp_evt) begin
        cmp_evt_q <= 1'b0;
      end
    end
  end

  // interrupt: sticky status, mask, and the documented enables
  wire [1:0] irq_status = {seq_done_flag_q, cmp_evt_q};
  wire [1:0] irq_enable = {seq_done_irq_en, cmp_irq_gate};
  assign o_irq = |(irq_status & irq_mask_q & irq_enable);

  // read data, taken in the cycle the request is first seen
  // result registers read unknown until their first conversion; software checks the flags first
  reg [31:0] rd_data;
  always @* begin
    rd_data = 32'h0000_0000;
    if (idx >= `ASC_IDX_RESULT_BASE && idx < `ASC_IDX_RESULT_BASE + 6'h10) begin
      rd_data = {16'h0000, result_q[idx[3:0]]};
    end else begin
      case (idx)
        `ASC_IDX_INT_TRIG_CTL: rd_data = {24'h000000, int_trig_ctl_q};
        `ASC_IDX_SEQ_CTL:      rd_data = {24'h000000, seq_ctl_q};
        `ASC_IDX_START:        rd_data = {31'h00000000, scan_q};
        `ASC_IDX_STATUS0:      rd_data = {24'h000000, seq_done_flag_q, 2'h0, (state_q != ST_IDLE),
                                          conv_cnt_q};
        `ASC_IDX_CONV_FLAGS:   rd_data = {16'h0000, conv_flag_q};
        `ASC_IDX_CMP_EN:       rd_data = {16'h0000, cmp_en_q};
        `ASC_IDX_IRQ_STATUS:   rd_data = {30'h00000000, irq_status};
        `ASC_IDX_IRQ_MASK:     rd_data = {30'h00000000, irq_mask_q};
        default:               rd_data = 32'h0000_0000;
      endcase
    end
  end

  // one wait state: ack follows the request by one edge and drops the next cycle, so the
  // write side-effects land on the edge where the master sees ack
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req & ~o_wb_ack;
      if (bus_req && !o_wb_ack && !i_wb_we) begin
        o_wb_dat <= rd_data;
      end
    end
  end

endmodule
`default_nettype wire

// >>> bench/asc_adc_seq_ctl_chk.sv
/*
  checker for the converter sequencing control: bus handshake, pulse widths, abort, freeze hold.
  assumes only the top module's ports; bound to every instance at the foot of this file.
*/
`include "asc_adc_seq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module asc_adc_seq_chk (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_reset,
  // register bus
  input wire logic       i_wb_cyc,
  input wire logic       i_wb_stb,
  input wire logic       i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic       o_wb_ack,
  // core and system
  input wire logic       o_conv_start,
  input wire logic       o_conv_abort,
  input wire logic       o_conv_hold,
  input wire logic       i_freeze,
  input wire logic       o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence bus_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  // the write lands at the ack edge; a launch pending then, or one due from a result taken at
  // that edge, would show within the next two cycles
  sequence seq_ctl_wr;
    i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr[7:2] == `ASC_IDX_SEQ_CTL;
  endsequence
  ack_wait_a: assert property (bus_req |=> o_wb_ack) else $error("no ack after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  ack_idle_a: assert property (!i_wb_cyc |=> !o_wb_ack) else $error("ack without cycle");
  start_pulse_a: assert property (o_conv_start |=> !o_conv_start) else $error("start too long");
  abort_pulse_a: assert property (o_conv_abort |=> !o_conv_abort) else $error("abort too long");
  seq_abort_a:
    assert property (seq_ctl_wr |=> !o_conv_start ##1 !o_conv_start) else $error("start after control write");
  abort_cause_a:
    assert property (o_conv_abort |-> $past(o_wb_ack && i_wb_we)) else $error("abort without a write");
  hold_freeze_a: assert property (o_conv_hold |-> i_freeze) else $error("hold without freeze");
  rst_quiet_a:
    assert property ($fell(i_reset) |-> !o_irq && !o_wb_ack && !o_conv_start) else $error("busy after reset");
endmodule
bind asc_adc_seq_ctl asc_adc_seq_chk u_chk (.i_clk_sys, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .i_wb_sel, .o_wb_ack, .o_conv_start, .o_conv_abort, .o_conv_hold, .i_freeze, .o_irq);
`default_nettype wire

// >>> bench/asc_adc_seq_ctl_tb.sv
/*
  self-checking bench for the converter sequencing control.
  assumes the design and its register header; the bench is both bus master and analog core.
*/
`include "asc_adc_seq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module asc_adc_seq_ctl_tb;
  logic        i_clk_sys = 1'h0, i_reset = 1'h1, i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic        i_conv_done = 1'h0, i_compare_hit = 1'h0, i_ext_trig = 1'h0, i_freeze = 1'h0, i_stop_mode = 1'h0;
  logic        o_wb_ack, o_conv_start, o_conv_abort, o_conv_hold, o_irq;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [3:0]  i_wb_sel = 4'h0;
  logic [11:0] i_conv_result = 12'h000;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
  int          n_errors = 0, num_checks = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  asc_adc_seq_ctl dut (.i_clk_sys, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .o_conv_start, .o_conv_abort, .o_conv_hold, .i_conv_done, .i_conv_result,
    .i_compare_hit, .i_ext_trig, .i_freeze, .i_stop_mode, .o_irq);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ends one idle edge after release, so back-to-back calls keep cyc low for a cycle
  task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we  <= we;
    i_wb_adr <= {idx, 2'h0};
    i_wb_dat <= d;
    i_wb_sel <= 4'h3;
    do @(posedge i_clk_sys);
    while (o_wb_ack !== 1'h1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    @(posedge i_clk_sys);
  endtask
  task automatic conv(input int n, input logic [11:0] base);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (o_conv_start !== 1'h1 && t < 40) begin
        @(posedge i_clk_sys);
        t++;
      end
      chk("conversion start", o_conv_start, 32'h1);
      i_conv_done   <= 1'h1;
      i_conv_result <= base + 12'(k);
      @(posedge i_clk_sys);
      i_conv_done <= 1'h0;
    end
  endtask
  task automatic starts(input int n, input int exp, input string what);
    int s = 0;
    repeat (n) begin
      @(posedge i_clk_sys);
      s += (o_conv_start === 1'h1);
    end
    chk(what, s, exp);
  endtask
  task automatic t_reset;
    chk("irq", o_irq, 32'h0);
    wb(1'h0, `ASC_IDX_SEQ_CTL, 32'h0);
    chk("sequence_control", rd, 32'h20);
    wb(1'h0, `ASC_IDX_INT_TRIG_CTL, 32'h0);
    chk("interrupt_trigger_control", rd, 32'h0);
    wb(1'h0, `ASC_IDX_IRQ_MASK, 32'h0);
    chk("irq mask", rd, 32'h3);
    wb(1'h1, 6'h3f, 32'hff);
    wb(1'h0, 6'h3f, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'h1, `ASC_IDX_SEQ_CTL, 32'hab);
    wb(1'h0, `ASC_IDX_SEQ_CTL, 32'h0);
    chk("sequence_control rw", rd, 32'hab);
  endtask
  task automatic t_len;
    int n;
    for (int code = 0; code < 16; code++) begin
      n = (code >= 1 && code <= 9) ? code : 10;
      wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h80 | (code << 3));
      wb(1'h1, `ASC_IDX_START, 32'h0);
      conv(n, 12'(code * 256));
      starts(12, 0, "extra starts");
      wb(1'h0, `ASC_IDX_CONV_FLAGS, 32'h0);
      chk("conversion flags", rd, (1 << n) - 1);
      wb(1'h0, 6'(`ASC_IDX_RESULT_BASE + n - 1), 32'h0);
      chk("right justified", rd, code * 256 + n - 1);
      wb(1'h0, `ASC_IDX_STATUS0, 32'h0);
      chk("status0", rd & 32'h9f, 32'h80);
      wb(1'h1, `ASC_IDX_CONV_FLAGS, 32'hffff);
      wb(1'h1, `ASC_IDX_STATUS0, 32'h80);
    end
  endtask
  task automatic t_irq;
    wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h08);
    wb(1'h1, `ASC_IDX_CMP_EN, 32'h1);
    i_compare_hit <= 1'h1;
    wb(1'h1, `ASC_IDX_START, 32'h0);
    conv(1, 12'h0ab);
    repeat (3) @(posedge i_clk_sys);
    chk("irq enables off", o_irq, 32'h0);
    wb(1'h1, `ASC_IDX_INT_TRIG_CTL, 32'h1);
    chk("compare irq", o_irq, 32'h1);
    wb(1'h1, `ASC_IDX_IRQ_MASK, 32'h0);
    chk("masked irq", o_irq, 32'h0);
    wb(1'h1, `ASC_IDX_IRQ_MASK, 32'h3);
    wb(1'h1, `ASC_IDX_IRQ_STATUS, 32'h1);
    chk("compare cleared", o_irq, 32'h0);
    wb(1'h1, `ASC_IDX_INT_TRIG_CTL, 32'h2);
    chk("seq done irq", o_irq, 32'h1);
    wb(1'h1, `ASC_IDX_STATUS0, 32'h80);
    chk("seq done cleared", o_irq, 32'h0);
  endtask
  task automatic t_fifo;
    wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h24);
    wb(1'h1, `ASC_IDX_CMP_EN, 32'hffff);
    wb(1'h1, `ASC_IDX_INT_TRIG_CTL, 32'h0d);
    wb(1'h1, `ASC_IDX_START, 32'h0);
    conv(4, 12'h200);
    for (int s = 1; s < 4; s++) begin
      i_ext_trig <= 1'h1;
      conv(4, 12'(512 + 4 * s));
      i_ext_trig <= 1'h0;
      wb(1'h0, `ASC_IDX_STATUS0, 32'h0);
      chk("fifo counter", rd[3:0], 4 * (s + 1) % 16);
    end
    wb(1'h0, 6'h1f, 32'h0);
    chk("left justified", rd, 32'h20f0);
    chk("fifo compare irq", o_irq, 32'h0);
    i_ext_trig <= 1'h1;
    conv(1, 12'h300);
    wb(1'h1, `ASC_IDX_START, 32'h0);
    chk("start abort", o_conv_abort, 32'h1);
    conv(1, 12'h3aa);
    wb(1'h0, `ASC_IDX_RESULT_BASE, 32'h0);
    chk("start clears counter", rd, 32'h3aa0);
    i_ext_trig <= 1'h0;
    wb(1'h1, `ASC_IDX_START, 32'h1);
    conv(6, 12'h100);
    wb(1'h0, `ASC_IDX_STATUS0, 32'h0);
    chk("scan counter", rd & 32'h1f, 32'h16);
    wb(1'h0, 6'h15, 32'h0);
    chk("scan result", rd, 32'h1050);
    wb(1'h1, `ASC_IDX_START, 32'h0);
    wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h24);
    chk("abort pulse", o_conv_abort, 32'h1);
    wb(1'h0, `ASC_IDX_STATUS0, 32'h0);
    chk("abort", rd & 32'h1f, 32'h0);
    i_compare_hit <= 1'h0;
  endtask
  // trigger mode m: idle pin level is ~m[0], active level m[0]
  task automatic t_trig;
    wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h08);
    for (int m = 0; m < 4; m++) begin
      i_stop_mode <= 1'h1;
      i_ext_trig  <= ~m[0];
      wb(1'h1, `ASC_IDX_INT_TRIG_CTL, (m << 3) | 4);
      i_ext_trig <= m[0];
      starts(10, 0, "stop mode");
      i_ext_trig <= ~m[0];
      wb(1'h1, `ASC_IDX_INT_TRIG_CTL, m << 3);
      i_stop_mode <= 1'h0;
      i_ext_trig  <= m[0];
      starts(10, 0, "trigger off");
      i_ext_trig <= ~m[0];
      wb(1'h1, `ASC_IDX_INT_TRIG_CTL, (m << 3) | 4);
      starts(8, 0, "idle level");
      i_ext_trig <= m[0];
      conv(1, 12'h055);
      starts(12, m[1], "level restart");
      i_ext_trig <= ~m[0];
      starts(10, 0, "release");
      wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h08);
    end
    wb(1'h1, `ASC_IDX_INT_TRIG_CTL, 32'h0);
  endtask
  task automatic t_freeze;
    for (int f = 0; f < 4; f++) begin
      wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h10 | f);
      wb(1'h1, `ASC_IDX_START, 32'h0);
      starts(6, 1, "first start");
      i_freeze <= 1'h1;
      repeat (2) @(posedge i_clk_sys);
      chk("hold", o_conv_hold, f == 3);
      if (f != 3) begin
        i_conv_done <= 1'h1;
        @(posedge i_clk_sys);
        i_conv_done <= 1'h0;
        starts(10, f != 2, "frozen start");
      end
      i_freeze <= 1'h0;
      starts(10, f == 2, "resume");
      chk("hold released", o_conv_hold, 32'h0);
      wb(1'h1, `ASC_IDX_SEQ_CTL, 32'h10);
    end
  endtask
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'h0;
    @(posedge i_clk_sys);
    t_reset;
    t_len;
    t_irq;
    t_fifo;
    t_trig;
    t_freeze;
    give_verdict;
  end
  // the whole run needs well under a tenth of this
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    n_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
